// ---- dth_core.sv ----
/*
  Synthesizer core: register file, loop mode control, step word choice,
  frequency clamp, phase accumulator with offset and the step word history
  engine. Assumes a byte-wide register port, a loop filter word presented
  every clock, and reference validity from the reference monitors.
*/
`timescale 1ns/10ps
module dth_core #(
  parameter int unsigned CYC_PER_MS = dth_pkg::CYC_MS
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Loop filter and reference monitor
  input  wire logic [47:0] loop_step_word,
  input  wire logic        ref_valid,
  input  wire logic [2:0]  auto_ref,
  input  wire logic        phase_lock_in,
  input  wire logic        freq_lock_in,
  // Multifunction input
  input  wire logic        mf_clear_history,
  // Synthesizer and status outputs
  output logic      [15:0] phase_out,
  output logic      [47:0] active_step_word,
  output logic      [1:0]  loop_state,
  output logic      [2:0]  active_ref,
  output logic             phase_lock_out,
  output logic             freq_lock_out,
  output logic             history_strobe,
  output logic             history_irq
);

  localparam int unsigned MSW = $clog2(CYC_PER_MS + 1);

  function automatic logic [47:0] wr_byte(input logic [47:0] v,
      input logic [15:0] a, input logic [15:0] base, input int nb,
      input logic [7:0] d);
    logic [47:0] r;
    logic [15:0] off;
    r   = v;
    off = a - base;
    for (int i = 0; i < 6; i++) begin
      if (i < nb && off == 16'(i)) begin
        r[i*8 +: 8] = d;
      end
    end
    return r;
  endfunction : wr_byte

  function automatic logic [7:0] rd_byte(input logic [47:0] v,
      input logic [15:0] a, input logic [15:0] base, input int nb);
    logic [7:0]  r;
    logic [15:0] off;
    r   = 8'h00;
    off = a - base;
    for (int i = 0; i < 6; i++) begin
      if (i < nb && off == 16'(i)) begin
        r = v[i*8 +: 8];
      end
    end
    return r;
  endfunction : rd_byte

  // Register file.
  logic [15:0] dac_cur, next_dac_cur;
  logic [47:0] freerun, next_freerun;
  logic [23:0] lim_lo, next_lim_lo, lim_hi, next_lim_hi;
  logic [15:0] ph_ofs, next_ph_ofs;
  logic [23:0] avg_tmr, next_avg_tmr;
  logic [7:0]  hist_ctl, next_hist_ctl, loop_mod, next_loop_mod;
  logic [7:0]  clr_ctl, next_clr_ctl, next_rdata;
  logic        clr_wr;

  // Loop control.
  dth_pkg::dth_state_e state, next_state;
  logic [2:0]  sel_ref, next_cur_ref;
  logic        ref_switch, enter_hold;
  logic [47:0] hold_word, next_hold_word, chosen, clamped;
  logic        next_plock, next_flock;

  // History engine.
  logic [MSW-1:0] ms_cnt, next_ms_cnt;
  logic           ms_tick;
  logic [23:0]    elapsed, next_elapsed, e1;
  logic [24:0]    chk, next_chk, chk0;
  logic           first_int, next_first_int, hist_valid, next_hist_valid;
  logic [47:0]    stored_avg, next_stored_avg, avg;
  logic           avg_done, upd_st, next_upd_st, clr_req, wipe, restart;
  logic           snap, keep, next_strobe;
  logic [47:0]    acc, next_acc;
  logic [15:0]    next_phase;

  always_comb begin
    next_dac_cur  = dac_cur;
    next_freerun  = freerun;
    next_lim_lo   = lim_lo;
    next_lim_hi   = lim_hi;
    next_ph_ofs   = ph_ofs;
    next_avg_tmr  = avg_tmr;
    next_hist_ctl = hist_ctl;
    next_loop_mod = loop_mod;
    next_clr_ctl  = clr_ctl;
    next_clr_ctl[dth_pkg::B_CLR_HIST] = 1'b0;
    clr_wr        = 1'b0;
    if (reg_wr) begin
      next_dac_cur  = 16'(wr_byte(48'(dac_cur), reg_addr,
        dth_pkg::A_DAC_CUR, 2, reg_wdata));
      next_freerun  = wr_byte(freerun, reg_addr, dth_pkg::A_FREERUN, 6,
        reg_wdata);  // see R5
      next_lim_lo   = 24'(wr_byte(48'(lim_lo), reg_addr,
        dth_pkg::A_LIM_LO, 3, reg_wdata));
      next_lim_hi   = 24'(wr_byte(48'(lim_hi), reg_addr,
        dth_pkg::A_LIM_HI, 3, reg_wdata));
      next_ph_ofs   = 16'(wr_byte(48'(ph_ofs), reg_addr,
        dth_pkg::A_PH_OFS, 2, reg_wdata));
      next_avg_tmr  = 24'(wr_byte(48'(avg_tmr), reg_addr,
        dth_pkg::A_AVG_TMR, 3, reg_wdata));  // see R9
      if (reg_addr == dth_pkg::A_HIST_CTL) next_hist_ctl = reg_wdata;
      if (reg_addr == dth_pkg::A_LOOP_MOD) next_loop_mod = reg_wdata;  // see R18
      if (reg_addr == dth_pkg::A_HIST_CLR) begin
        next_clr_ctl = reg_wdata;
        next_clr_ctl[dth_pkg::B_CLR_HIST] = 1'b0;
        clr_wr = reg_wdata[dth_pkg::B_CLR_HIST];  // see R14
      end
    end
    next_rdata = reg_rdata;
    if (reg_rd) begin
      next_rdata = rd_byte(48'(dac_cur), reg_addr, dth_pkg::A_DAC_CUR, 2)
        | rd_byte(freerun, reg_addr, dth_pkg::A_FREERUN, 6)
        | rd_byte(48'(lim_lo), reg_addr, dth_pkg::A_LIM_LO, 3)
        | rd_byte(48'(lim_hi), reg_addr, dth_pkg::A_LIM_HI, 3)
        | rd_byte(48'(ph_ofs), reg_addr, dth_pkg::A_PH_OFS, 2)
        | rd_byte(48'(avg_tmr), reg_addr, dth_pkg::A_AVG_TMR, 3)
        | rd_byte(48'(hist_ctl), reg_addr, dth_pkg::A_HIST_CTL, 1)
        | rd_byte(48'(loop_mod), reg_addr, dth_pkg::A_LOOP_MOD, 1)
        | rd_byte(48'(clr_ctl), reg_addr, dth_pkg::A_HIST_CLR, 1)
        | rd_byte(stored_avg, reg_addr, dth_pkg::A_HIST_AVG, 6)
        | rd_byte({44'h0, state, hist_valid, upd_st}, reg_addr,
                  dth_pkg::A_STATUS, 1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dac_cur   <= '0;
      freerun   <= '0;
      lim_lo    <= dth_pkg::LIM_LO_RST;  // see R8
      lim_hi    <= dth_pkg::LIM_HI_RST;  // see R8
      ph_ofs    <= '0;
      avg_tmr   <= dth_pkg::TMR_RST;
      hist_ctl  <= '0;
      loop_mod  <= '0;
      clr_ctl   <= '0;
      reg_rdata <= '0;
    end else begin
      dac_cur   <= next_dac_cur;
      freerun   <= next_freerun;
      lim_lo    <= next_lim_lo;
      lim_hi    <= next_lim_hi;
      ph_ofs    <= next_ph_ofs;
      avg_tmr   <= next_avg_tmr;
      hist_ctl  <= next_hist_ctl;
      loop_mod  <= next_loop_mod;
      clr_ctl   <= next_clr_ctl;
      reg_rdata <= next_rdata;
    end
  end

  // Loop control and step word choice.
  always_comb begin
    sel_ref = loop_mod[dth_pkg::B_FORCE_REF] ? loop_mod[2:0] : auto_ref;  // see R18
    next_state = state;
    unique case (state)
      dth_pkg::DTH_FREERUN: if (ref_valid) next_state = dth_pkg::DTH_CLOSED;
      dth_pkg::DTH_CLOSED: begin
        if (!ref_valid) next_state = dth_pkg::DTH_HOLD;
        else if (sel_ref != active_ref) next_state = dth_pkg::DTH_SWITCH;
      end
      // A switch holds over for one clock and recovers at once.
      dth_pkg::DTH_SWITCH: next_state = dth_pkg::DTH_CLOSED;  // see R19
      dth_pkg::DTH_HOLD: if (ref_valid) next_state = dth_pkg::DTH_CLOSED;  // see R22
    endcase
    if (loop_mod[dth_pkg::B_FORCE_FR]) begin
      next_state = dth_pkg::DTH_FREERUN;  // see R18
    end else if (loop_mod[dth_pkg::B_USER_HOLD]) begin
      next_state = dth_pkg::DTH_HOLD;  // see R22
    end
    ref_switch = sel_ref != active_ref
      && (next_state == dth_pkg::DTH_SWITCH
          || (state != dth_pkg::DTH_CLOSED
              && next_state == dth_pkg::DTH_CLOSED));
    next_cur_ref = ref_switch ? sel_ref : active_ref;
    enter_hold = (next_state == dth_pkg::DTH_HOLD
                  || next_state == dth_pkg::DTH_SWITCH)
      && state != dth_pkg::DTH_HOLD && state != dth_pkg::DTH_SWITCH;
    next_hold_word = hold_word;
    if (enter_hold) begin
      if (hist_valid) next_hold_word = stored_avg;  // see R20
      else if (hist_ctl[dth_pkg::B_FALLBACK]) next_hold_word = active_step_word;  // see R21
      else next_hold_word = freerun;  // see R21
    end
    unique case (state)
      dth_pkg::DTH_FREERUN: chosen = freerun;  // see R5
      dth_pkg::DTH_CLOSED:  chosen = loop_step_word;  // see R6
      default:              chosen = hold_word;  // see R20
    endcase
    // Only the upper half is compared so the limits stay 24 bits wide.
    if (chosen[47:24] > lim_hi) clamped = {lim_hi, 24'h000000};  // see R7, R23
    else if (chosen[47:24] < lim_lo) clamped = {lim_lo, 24'h000000};  // see R23
    else clamped = chosen;
    // Lock status freezes across a switch and drops outside closed loop.
    next_plock = phase_lock_out;
    next_flock = freq_lock_out;
    if (next_state == dth_pkg::DTH_CLOSED && state != dth_pkg::DTH_SWITCH) begin
      next_plock = phase_lock_in;
      next_flock = freq_lock_in;
    end else if (next_state != dth_pkg::DTH_SWITCH
                 && state != dth_pkg::DTH_SWITCH) begin
      next_plock = 1'b0;
      next_flock = 1'b0;
    end  // see R19
    next_acc   = acc + clamped;  // see R1, R2
    next_phase = acc[47:32] + ph_ofs;  // see R3
  end

  // History engine.
  always_comb begin
    ms_tick      = ms_cnt == MSW'(CYC_PER_MS - 1);
    next_ms_cnt  = ms_tick ? '0 : ms_cnt + 1'b1;
    clr_req      = clr_wr || mf_clear_history;  // see R14
    wipe = clr_req || (ref_switch && !hist_ctl[dth_pkg::B_PERSIST]);  // see R13
    restart      = clr_req || ref_switch;  // see R13
    chk0         = 25'(avg_tmr >> hist_ctl[2:0]);  // see R16
    if (chk0 == 25'h0000000) chk0 = 25'h0000001;
    e1           = elapsed + 1'b1;
    next_elapsed = elapsed;
    next_chk     = chk;
    next_first_int = first_int;
    next_hist_valid = hist_valid;
    next_stored_avg = stored_avg;
    next_strobe  = 1'b0;
    snap         = 1'b0;
    keep         = 1'b0;
    if (avg_done) begin
      next_stored_avg = avg;  // see R11
      next_hist_valid = 1'b1;
      next_strobe     = 1'b1;  // see R12
    end
    if (restart) begin
      next_elapsed = '0;
    end else if (ms_tick && state == dth_pkg::DTH_CLOSED) begin
      next_elapsed = e1;
      if (e1 >= avg_tmr) begin
        snap           = 1'b1;  // see R15, R17
        next_elapsed   = '0;
        next_first_int = 1'b0;
      end else if (first_int && hist_ctl[2:0] != 3'h0
                   && 25'(e1) >= chk) begin
        snap     = 1'b1;  // see R16
        keep     = 1'b1;
        next_chk = {chk[23:0], 1'b0};
      end
    end
    if (wipe) begin
      next_hist_valid = 1'b0;
      next_first_int  = 1'b1;
      next_chk        = chk0;
    end
    // A new strobe wins over a software clear of the status bit.
    next_upd_st = upd_st;
    if (reg_wr && reg_addr == dth_pkg::A_STATUS
        && reg_wdata[dth_pkg::B_ST_UPD]) next_upd_st = 1'b0;
    if (avg_done && hist_ctl[dth_pkg::B_UPD_MASK]) next_upd_st = 1'b1;  // see R12
  end

  dth_avg #(
    .DW (48),
    .CW (24)
  ) u_avg (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .sample_en (ms_tick && state == dth_pkg::DTH_CLOSED && !restart),
    .sample    (loop_step_word),
    .restart   (restart),
    .snap      (snap),
    .keep      (keep),
    .avg       (avg),
    .avg_done  (avg_done)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state            <= dth_pkg::DTH_FREERUN;
      active_ref       <= 3'h0;
      hold_word        <= '0;
      active_step_word <= '0;
      acc              <= '0;
      phase_out        <= '0;
      loop_state       <= 2'h0;
      phase_lock_out   <= 1'b0;
      freq_lock_out    <= 1'b0;
      ms_cnt           <= '0;
      elapsed          <= '0;
      chk              <= 25'h0000001;
      first_int        <= 1'b1;
      hist_valid       <= 1'b0;  // see R15
      stored_avg       <= '0;
      upd_st           <= 1'b0;
      history_strobe   <= 1'b0;
      history_irq      <= 1'b0;
    end else begin
      state            <= next_state;
      active_ref       <= next_cur_ref;
      hold_word        <= next_hold_word;
      active_step_word <= clamped;
      acc              <= next_acc;
      phase_out        <= next_phase;
      loop_state       <= next_state;
      phase_lock_out   <= next_plock;
      freq_lock_out    <= next_flock;
      ms_cnt           <= next_ms_cnt;
      elapsed          <= next_elapsed;
      chk              <= next_chk;
      first_int        <= next_first_int;
      hist_valid       <= next_hist_valid;
      stored_avg       <= next_stored_avg;
      upd_st           <= next_upd_st;
      history_strobe   <= next_strobe;
      history_irq      <= next_upd_st;
    end
  end

endmodule : dth_core

// ---- dth_pkg.sv ----
/*
  Shared constants of the synthesizer and holdover block: addresses,
  fields, reset values, states and timing. Assumes 16-bit byte addresses.
*/
// Contract
// R1 - Accumulator adds the step word every clock, modulo 2^48.
// R2 - Overflow keeps the excess.
// R3 - 16-bit phase offset adds to accumulator; full range is one cycle.
// R4 - Software sets step words for at least 62.5 MHz.
// R5 - Free-run uses the free-running step word.
// R6 - Closed loop uses the loop filter word.
// R7 - 24-bit clamp limits bound frequency in all modes.
// R8 - Clamp limits reset to zero and full scale.
// R9 - Averaging interval is a 24-bit millisecond timer.
// R10 - Software never sets an interval of zero.
// R11 - Each interval end stores an independent mean of loop words.
// R12 - Each interval end pulses a strobe setting a masked status.
// R13 - Reference switch restarts averaging; clears history unless persistent.
// R14 - Clear bit 2 or clear input erases history.
// R15 - Without history the first value waits a full interval.
// R16 - After a clear, K gives averages at interval/2^K, doubling.
// R17 - After the first interval, averages come every full interval.
// R18 - Loop mode forces holdover, free-run or a reference.
// R19 - Switchover briefly holds over, lock status held.
// R20 - Holdover uses the last stored average when history exists.
// R21 - Without history, bit 4 picks free-run or last applied word.
// R22 - Valid reference ends holdover unless user holdover bit 6 is set.
// R23 - Clamp compares upper 24 bits, substitutes zero-padded limit.
package dth_pkg;

  localparam int unsigned SW_W  = 48;
  localparam int unsigned LIM_W = 24;
  localparam int unsigned PH_W  = 16;
  localparam int unsigned AV_W  = 24;

  // Register byte addresses; least significant byte at the lowest address.
  localparam logic [15:0] A_DAC_CUR  = 16'h0213;
  localparam logic [15:0] A_FREERUN  = 16'h0300;
  localparam logic [15:0] A_LIM_LO   = 16'h0307;
  localparam logic [15:0] A_LIM_HI   = 16'h030a;
  localparam logic [15:0] A_PH_OFS   = 16'h030d;
  localparam logic [15:0] A_AVG_TMR  = 16'h0318;
  localparam logic [15:0] A_HIST_CTL = 16'h031b;
  localparam logic [15:0] A_LOOP_MOD = 16'h0a01;
  localparam logic [15:0] A_HIST_CLR = 16'h0a03;
  localparam logic [15:0] A_HIST_AVG = 16'h0d14;
  localparam logic [15:0] A_STATUS   = 16'h0d1a;

  // History control fields.
  localparam int unsigned B_PERSIST  = 3;
  localparam int unsigned B_FALLBACK = 4;
  localparam int unsigned B_UPD_MASK = 5;
  // Loop mode fields.
  localparam int unsigned B_FORCE_REF = 3;
  localparam int unsigned B_FORCE_FR  = 5;
  localparam int unsigned B_USER_HOLD = 6;
  // Clear control and status fields.
  localparam int unsigned B_CLR_HIST  = 2;
  localparam int unsigned B_ST_UPD    = 0;
  localparam int unsigned B_ST_VALID  = 1;

  localparam logic [LIM_W-1:0] LIM_LO_RST = 24'h000000;
  localparam logic [LIM_W-1:0] LIM_HI_RST = 24'hffffff;
  localparam logic [AV_W-1:0]  TMR_RST    = 24'h000001;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_MS        = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    DTH_FREERUN = 2'b00,
    DTH_CLOSED  = 2'b01,
    DTH_SWITCH  = 2'b11,
    DTH_HOLD    = 2'b10
  } dth_state_e;

endpackage : dth_pkg

// ---- dth_avg.sv ----
/*
  Memoryless averager: sums samples and, on a snap, divides the sum by
  the count with a serial restoring divider. Assumes snaps far apart.
*/
`timescale 1ns/10ps
module dth_avg #(
  parameter int unsigned DW = 48,
  parameter int unsigned CW = 24
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // Samples and control
  input  wire logic          sample_en,
  input  wire logic [DW-1:0] sample,
  input  wire logic          restart,
  input  wire logic          snap,
  input  wire logic          keep,
  // Result
  output logic      [DW-1:0] avg,
  output logic               avg_done
);

  localparam int unsigned SW = DW + CW;
  localparam int unsigned NW = $clog2(SW + 1);

  logic [SW-1:0] sum, next_sum, quo, next_quo;
  logic [CW-1:0] cnt, next_cnt, dvs, next_dvs;
  logic [CW:0]   rem, next_rem, rem_sh;
  logic [NW-1:0] steps, next_steps;
  logic          busy, next_busy;
  logic [DW-1:0] next_avg;
  logic          next_done;
  logic [SW-1:0] sum_in;
  logic [CW-1:0] cnt_in;

  always_comb begin
    sum_in     = sample_en ? sum + SW'(sample) : sum;
    cnt_in     = sample_en ? cnt + 1'b1 : cnt;
    next_sum   = sum_in;
    next_cnt   = cnt_in;
    next_quo   = quo;
    next_dvs   = dvs;
    next_rem   = rem;
    next_steps = steps;
    next_busy  = busy;
    next_avg   = avg;
    next_done  = 1'b0;
    rem_sh     = {rem[CW-1:0], quo[SW-1]};
    if (restart) begin
      next_sum  = '0;
      next_cnt  = '0;
      next_busy = 1'b0;
    end else begin
      if (snap && !busy && cnt_in != '0) begin
        next_quo   = sum_in;
        next_dvs   = cnt_in;
        next_rem   = '0;
        next_steps = NW'(SW);
        next_busy  = 1'b1;
        if (!keep) begin
          // Each full interval starts from nothing.  // see R11
          next_sum = '0;
          next_cnt = '0;
        end
      end else if (busy) begin
        if (rem_sh >= {1'b0, dvs}) begin
          next_rem = rem_sh - {1'b0, dvs};
          next_quo = {quo[SW-2:0], 1'b1};
        end else begin
          next_rem = rem_sh;
          next_quo = {quo[SW-2:0], 1'b0};
        end
        next_steps = steps - 1'b1;
        if (steps == NW'(1)) begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_avg  = next_quo[DW-1:0];  // see R11
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sum      <= '0;
      cnt      <= '0;
      quo      <= '0;
      dvs      <= '0;
      rem      <= '0;
      steps    <= '0;
      busy     <= 1'b0;
      avg      <= '0;
      avg_done <= 1'b0;
    end else begin
      sum      <= next_sum;
      cnt      <= next_cnt;
      quo      <= next_quo;
      dvs      <= next_dvs;
      rem      <= next_rem;
      steps    <= next_steps;
      busy     <= next_busy;
      avg      <= next_avg;
      avg_done <= next_done;
    end
  end

endmodule : dth_avg

// ---- dth_core_monitor.sv ----
/* Port checker for dth_core, bound to every instance.
   Assumes one clock domain and synchronous active-high reset. */
`timescale 1ns/10ps
module dth_core_monitor #(
  parameter int unsigned CYC_PER_MS = 10
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Watched ports
  input wire logic [47:0] loop_step_word,
  input wire logic [47:0] active_step_word,
  input wire logic [1:0]  loop_state,
  input wire logic [2:0]  active_ref,
  input wire logic        phase_lock_out,
  input wire logic        freq_lock_out,
  input wire logic        history_strobe,
  input wire logic        history_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic opn;
  // Free-run and holdover both have state bit 0 clear.
  assign opn = ~loop_state[0];
  a_strobe_pulse: assert property (
    history_strobe |=> !history_strobe) else $error("strobe too long");
  a_irq_cause: assert property (
    $rose(history_irq) |-> history_strobe || $past(history_strobe))
    else $error("status set without strobe");
  a_switch_brief: assert property (
    loop_state == dth_pkg::DTH_SWITCH |=>
    loop_state != dth_pkg::DTH_SWITCH) else $error("switch not brief");
  a_switch_lock: assert property (
    loop_state == dth_pkg::DTH_SWITCH |->
    $stable(phase_lock_out) && $stable(freq_lock_out))
    else $error("lock changed in switch");
  a_open_unlock: assert property (
    opn && $past(opn) |-> !phase_lock_out && !freq_lock_out)
    else $error("lock shown with loop open");
  a_closed_word: assert property (
    loop_state == dth_pkg::DTH_CLOSED &&
    $past(loop_state) == dth_pkg::DTH_CLOSED |->
    active_step_word == $past(loop_step_word)) else $error("closed word");
  a_hold_steady: assert property (
    loop_state == dth_pkg::DTH_HOLD &&
    $past(loop_state) == dth_pkg::DTH_HOLD &&
    $past(loop_state, 2) == dth_pkg::DTH_HOLD |-> $stable(active_step_word))
    else $error("holdover word moved");
  a_ref_steady: assert property (
    loop_state == dth_pkg::DTH_CLOSED &&
    $past(loop_state) == dth_pkg::DTH_CLOSED |-> $stable(active_ref))
    else $error("reference changed without switch");
  c_strobe: cover property (history_strobe);
  c_switch: cover property (loop_state == dth_pkg::DTH_SWITCH);
  c_hold: cover property (loop_state == dth_pkg::DTH_HOLD);
endmodule : dth_core_monitor

bind dth_core dth_core_monitor #(.CYC_PER_MS(CYC_PER_MS))
  u_mon (
  .clk_sys(clk_sys), .rst(rst), .loop_step_word(loop_step_word),
  .active_step_word(active_step_word), .loop_state(loop_state),
  .active_ref(active_ref), .phase_lock_out(phase_lock_out),
  .freq_lock_out(freq_lock_out), .history_strobe(history_strobe),
  .history_irq(history_irq));

// ---- dth_loop_model.sv ----
/* Loop filter and reference monitor model facing dth_core.
   Assumes the bench sets the filter target word and reference presence. */
`timescale 1ns/10ps
module dth_loop_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Bench controls
  input  wire logic        ref_on,
  input  wire logic [47:0] word_set,
  // Loop side
  output logic      [47:0] loop_step_word,
  output logic             ref_valid,
  output logic      [2:0]  auto_ref,
  output logic             phase_lock_in,
  output logic             freq_lock_in
);
  logic [1:0] lk;
  // Phase lock needs two clocks of reference and trails validity by one clock; frequency lock rises with validity.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      loop_step_word <= 48'h0;
      ref_valid <= 1'b0;
      lk <= 2'h0;
    end else begin
      loop_step_word <= word_set;
      ref_valid <= ref_on;
      lk <= ref_on ? {lk[0], 1'b1} : 2'h0;
    end
  end
  assign auto_ref = 3'h0;
  assign phase_lock_in = lk[1];
  assign freq_lock_in = lk[0];
endmodule : dth_loop_model

// ---- testbench.sv ----
/* Self-checking bench for dth_core with the loop model.
   Assumes 100 clocks per millisecond in this run. */
`timescale 1ns/10ps
module testbench;
  localparam logic [47:0] FR = 48'h6000_0000_0000;
  localparam logic [47:0] W1 = 48'h5a00_0000_0000;
  localparam logic [1:0] CL = dth_pkg::DTH_CLOSED, HO = dth_pkg::DTH_HOLD;
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic mf_clr = 1'b0, ref_on = 1'b0;
  logic [15:0] reg_addr = 16'h0, ph;
  logic [7:0] reg_wdata = 8'h0, rdata;
  logic [47:0] word_set = W1, lw, asw;
  logic [1:0] st;
  logic [2:0] ar, aref;
  logic rv, pli, fli, pl, fl, hs, hi;
  int err_total = 0, checks = 0;
  always #50 clk_sys = ~clk_sys;
  dth_core #(.CYC_PER_MS(100)) dth_core_inst (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata), .loop_step_word(lw),
    .ref_valid(rv), .auto_ref(ar), .phase_lock_in(pli), .freq_lock_in(fli),
    .mf_clear_history(mf_clr), .phase_out(ph), .active_step_word(asw),
    .loop_state(st), .active_ref(aref), .phase_lock_out(pl),
    .freq_lock_out(fl), .history_strobe(hs), .history_irq(hi));
  dth_loop_model dth_loop_model_inst (.clk_sys(clk_sys), .rst(rst),
    .ref_on(ref_on), .word_set(word_set), .loop_step_word(lw),
    .ref_valid(rv), .auto_ref(ar), .phase_lock_in(pli), .freq_lock_in(fli));
  task chk(input string n, input logic [47:0] s, e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task rc(input logic [15:0] a, input string n, input logic [7:0] m, e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(n, 48'(rdata & m), 48'(e));
  endtask : rc
  task wrn(input logic [15:0] a, input logic [47:0] v, input int n);
    for (int i = 0; i < n; i++) wr(a + 16'(i), v[8*i +: 8]);
  endtask : wrn
  task wst(input logic [1:0] s);
    for (int i = 0; i < 50 && st !== s; i++) @(negedge clk_sys);
    // The applied word trails the state by one clock.
    @(negedge clk_sys);
    chk("state", 48'(st), 48'(s));
  endtask : wst
  task wsb(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (hs !== 1'b1 && n < 600);
  endtask : wsb
  task t_regs;
    rc(dth_pkg::A_LIM_LO, "lim_lo", 8'hff, 8'h00);
    rc(dth_pkg::A_LIM_HI, "lim_hi", 8'hff, 8'hff);
    rc(dth_pkg::A_AVG_TMR, "timer", 8'hff, 8'h01);
    wr(dth_pkg::A_HIST_AVG, 8'h5a);
    rc(dth_pkg::A_HIST_AVG, "avg_ro", 8'hff, 8'h00);
    rc(16'h0400, "unmapped", 8'hff, 8'h00);
  endtask : t_regs
  task t_dds;
    logic [15:0] p;
    wrn(dth_pkg::A_PH_OFS, 48'h0123, 2);
    wrn(dth_pkg::A_FREERUN, FR, 6);
    repeat (3) @(negedge clk_sys);
    chk("freerun", asw, FR);
    chk("offset", 48'(13'(ph - 16'h0123)), 48'h0);
    for (int i = 0; i < 4; i++) begin
      p = ph;
      @(negedge clk_sys);
      chk("phase_step", 48'(16'(ph - p)), 48'h6000);
    end
  endtask : t_dds
  task t_clamp;
    wr(dth_pkg::A_LIM_LO + 16'h2, 8'h70);
    repeat (3) @(negedge clk_sys);
    chk("clamp_lo", asw, 48'h7000_0000_0000);
    wr(dth_pkg::A_LIM_LO + 16'h2, 8'h00);
    wr(dth_pkg::A_LIM_HI + 16'h2, 8'h50);
    repeat (3) @(negedge clk_sys);
    chk("clamp_hi", asw, 48'h50ff_ff00_0000);
    wr(dth_pkg::A_LIM_HI + 16'h2, 8'hff);
  endtask : t_clamp
  task t_hist;
    int g;
    wrn(dth_pkg::A_AVG_TMR, 48'h2, 3);
    wr(dth_pkg::A_HIST_CTL, 8'h21);
    ref_on = 1'b1;
    wst(CL);
    wsb(g);
    wsb(g);
    chk("half_gap", 48'(g > 95 && g < 105), 48'h1);
    wsb(g);
    chk("full_gap", 48'(g > 195 && g < 205), 48'h1);
    rc(dth_pkg::A_HIST_AVG + 16'h5, "avg_hi", 8'hff, 8'h5a);
    rc(dth_pkg::A_HIST_AVG, "avg_lo", 8'hff, 8'h00);
    chk("irq", 48'(hi), 48'h1);
  endtask : t_hist
  task t_hold;
    int g;
    wsb(g);
    word_set = 48'h5c00_0000_0000;
    repeat (3) @(negedge clk_sys);
    ref_on = 1'b0;
    wst(HO);
    chk("hold_word", asw, W1);
    wr(dth_pkg::A_LOOP_MOD, 8'h40);
    ref_on = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk("user_hold", 48'(st), 48'(HO));
    wr(dth_pkg::A_LOOP_MOD, 8'h00);
    wst(CL);
  endtask : t_hold
  task t_switch;
    int g;
    wr(dth_pkg::A_HIST_CTL, 8'h20);
    wsb(g);
    wr(dth_pkg::A_LOOP_MOD, 8'h0d);
    repeat (3) @(negedge clk_sys);
    wst(CL);
    chk("force_ref", 48'(aref), 48'h5);
    rc(dth_pkg::A_STATUS, "wiped", 8'h02, 8'h00);
    wr(dth_pkg::A_HIST_CTL, 8'h28);
    wsb(g);
    wr(dth_pkg::A_LOOP_MOD, 8'h0b);
    repeat (3) @(negedge clk_sys);
    rc(dth_pkg::A_STATUS, "kept", 8'h02, 8'h02);
    wr(dth_pkg::A_LOOP_MOD, 8'h20);
    wst(dth_pkg::DTH_FREERUN);
    wr(dth_pkg::A_LOOP_MOD, 8'h00);
    wst(CL);
  endtask : t_switch
  task t_clear;
    int g;
    wr(dth_pkg::A_HIST_CTL, 8'h20);
    wr(dth_pkg::A_HIST_CLR, 8'h04);
    rc(dth_pkg::A_STATUS, "sw_clear", 8'h02, 8'h00);
    wsb(g);
    chk("first_wait", 48'(g > 150), 48'h1);
    @(negedge clk_sys);
    mf_clr = 1'b1;
    @(negedge clk_sys);
    mf_clr = 1'b0;
    rc(dth_pkg::A_STATUS, "pin_clear", 8'h02, 8'h00);
  endtask : t_clear
  task t_fb;
    for (int f = 0; f < 2; f++) begin
      ref_on = 1'b0;
      wst(HO);
      wr(dth_pkg::A_HIST_CTL, f[0] ? 8'h10 : 8'h00);
      wr(dth_pkg::A_HIST_CLR, 8'h04);
      word_set = 48'h4d00_0000_0000;
      ref_on = 1'b1;
      wst(CL);
      repeat (3) @(negedge clk_sys);
      ref_on = 1'b0;
      wst(HO);
      chk("fallback", asw, f[0] ? word_set : FR);
    end
  endtask : t_fb
  task results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    t_regs();
    t_dds();
    t_clamp();
    t_hist();
    t_hold();
    t_switch();
    t_clear();
    t_fb();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    results();
  end
endmodule : testbench
